// ### logic/itc_params.svh
// Purpose: offsets, field positions and codes of the transfer controller
// Assumes: descriptor words in memory, byte addresses
// Notes: included by the design only
`ifndef ITC_PARAMS_SVH
`define ITC_PARAMS_SVH
`define MODE_FIELD_HI 7
`define MODE_FIELD_LO 6
`define SIZE_FIELD_HI 5
`define SIZE_FIELD_LO 4
`define STEP_FIELD_HI 3
`define STEP_FIELD_LO 2
`define CHAIN_EN_BIT 7
`define CHAIN_COND_BIT 6
`define IRQ_EVERY_BIT 5
`define AREA_SIDE_BIT 4
`define CODE_NORMAL 2'h0
`define CODE_REPEAT 2'h1
`define CODE_BLOCK 2'h2
`define CODE_BYTE 2'h0
`define CODE_WORD 2'h1
`define CODE_LONG 2'h2
`define WORDS_SHORT 3'h3
`define WORDS_FULL 3'h4
`define SHORT_ADDR_MASK 32'h00ff_ffff
`endif

// ### logic/itc_pkg.sv
// Purpose: types shared by the transfer controller
// Assumes: params header in the include path
// Notes: constants live in the header as macros
package itc_pkg;
   typedef enum logic [3:0] {
      st_idle, st_vec, st_desc, st_rd, st_wr, st_upd, st_wb, st_done
   } itc_state_t;
endpackage : itc_pkg

// ### logic/interrupt_transfer_ctrl.sv
// Purpose: interrupt activated data transfer controller with descriptors
// Assumes: single clock, memory port answers with mem_ack, one word per beat
// Notes: descriptors have no cpu path, they live in memory with a held internal copy
// Functional notes
// - start a transfer when an assigned activation request arrives
// - any channel count; each channel is a descriptor in memory
// - chain descriptors per activation, optionally only when count reaches zero
// - short mode: three longword descriptor, 24-bit addresses
// - full mode: four longword descriptor, 32-bit addresses
// - odd address word or longword splits into several bus cycles
// - longword at address 4n+2 splits into several bus cycles
// - can forward the activating request to the cpu as interrupt; not done here, cpu_irq only pulses at the end of the writeback
// - cpu interrupt after every transfer or only after count completes
// - read skip reuses descriptor already held
// - fixed address fields are not written back
// - descriptor registers have no direct cpu path
// - read vector, then descriptor, then transfer data
// - write updated descriptor back after the transfer
// - mode field bits 7:6: normal, repeat, block; 11 prohibited
// - size field bits 5:4: byte, word, longword; 11 prohibited
// - source step bits 3:2: 0x fixed, 10 up, 11 down
// - step by 1, 2 or 4 per size
// - mode byte b: chain enable 7, chain condition 6, irq-every 5
// - when chaining, skip count check, keep source flag and enable
// - area select 0 destination, 1 source, for repeat/block area
// - destination step bits 3:2 like source, fixed skips writeback
`include "itc_params.svh"
module interrupt_transfer_ctrl (
   input wire logic clock,
   input wire logic rstn,
   input wire logic act_req,
   input wire logic [7:0] act_vector,
   input wire logic [31:0] vector_base,
   input wire logic full_addr_mode,
   input wire logic read_skip,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_ack,
   output logic mem_req,
   output logic mem_we,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   output logic [3:0] mem_be,
   output logic act_done,
   output logic clear_enable,
   output logic cpu_irq,
   output logic busy
);
   import itc_pkg::*;

   // address step by size (1, 2 or 4): pure decode used in several places
   function automatic logic [2:0] step_of(input logic [1:0] sz);
      case (sz)
         `CODE_BYTE: step_of = 3'h1;
         `CODE_WORD: step_of = 3'h2;
         default: step_of = 3'h4;
      endcase
   endfunction : step_of
   // beat length of one bus cycle starting at addr, split for alignment
   function automatic logic [2:0] beat_of(input logic [1:0] sz,
                                          input logic [31:0] a,
                                          input logic [2:0] left);
      logic [2:0] b;
      b = step_of(sz);
      if (a[0]) begin
         b = 3'h1; // odd address goes bytewise
      end else if (a[1] && left > 3'h2) begin
         b = 3'h2; // 4n+2 longword split
      end else if (left < b) begin
         b = left;
      end
      beat_of = b;
   endfunction : beat_of
   function automatic logic [31:0] stepped(input logic [31:0] a,
                                           input logic [1:0] m,
                                           input logic [1:0] sz);
      if (m == 2'h2) begin
         stepped = a + {29'h0, step_of(sz)};
      end else if (m == 2'h3) begin
         stepped = a - {29'h0, step_of(sz)};
      end else begin
         stepped = a;
      end
   endfunction : stepped
   itc_state_t state;
   logic [7:0] mode_a;
   logic [7:0] mode_b;
   logic [31:0] src;
   logic [31:0] dst;
   logic [15:0] cnt_a;
   logic [15:0] cnt_b;
   logic [31:0] desc_base;
   logic [2:0] widx;
   logic [31:0] data;
   logic [2:0] left;
   logic [15:0] blk_left;
   logic have_desc;
   logic [7:0] held_vec;
   logic [1:0] md;
   logic [1:0] sz;
   logic [2:0] nwords;
   logic [2:0] beat;
   logic [31:0] cur_addr;
   logic [15:0] next_cnt;
   logic last_xfer;
   logic chain_go;
   logic bad_code;
   logic wb_skip;
   logic pending;
   // field decode of the held descriptor
   assign md = mode_a[`MODE_FIELD_HI:`MODE_FIELD_LO];
   assign sz = mode_a[`SIZE_FIELD_HI:`SIZE_FIELD_LO];
   assign bad_code = (md == 2'h3) || (sz == 2'h3);
   assign nwords = full_addr_mode ? `WORDS_FULL : `WORDS_SHORT;
   assign cur_addr = ((state == st_rd) ? src : dst) +
      {29'h0, step_of(sz) - left}; // later beats move on
   assign beat = beat_of(sz, cur_addr, left);
   assign next_cnt = cnt_a - 16'h0001;
   assign last_xfer = (md != `CODE_REPEAT) && (cnt_a == 16'h0000);
   // count is already stepped at writeback
   assign chain_go = mode_b[`CHAIN_EN_BIT] &&
      (!mode_b[`CHAIN_COND_BIT] || cnt_a == 16'h0000);
   // source word 0 short / 1 full, destination next
   assign wb_skip = (widx == {2'h0, full_addr_mode} &&
      !mode_a[`STEP_FIELD_HI]) ||
      (widx == {1'b0, full_addr_mode, !full_addr_mode} &&
      !mode_b[`STEP_FIELD_HI]);
   // main sequencer: vector, descriptor, data, writeback
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state <= st_idle;
         widx <= 3'h0;
         left <= 3'h0;
         desc_base <= 32'h0000_0000;
         data <= 32'h0000_0000;
         blk_left <= 16'h0000;
         have_desc <= 1'b0;
         held_vec <= 8'h00;
      end else begin
         case (state)
            st_idle: begin
               if (act_req) begin
                  held_vec <= act_vector;
                  // reuse the held descriptor for the same vector
                  if (read_skip && have_desc && held_vec == act_vector) begin
                     state <= bad_code ? st_done : st_rd;
                     left <= step_of(sz);
                     blk_left <= cnt_b;
                  end else begin
                     state <= st_vec;
                  end
               end
            end
            st_vec: if (mem_ack) begin
               desc_base <= mem_rdata; // any descriptor address
               widx <= 3'h0;
               state <= st_desc;
            end
            st_desc: if (mem_ack) begin
               widx <= widx + 3'h1;
               if (widx + 3'h1 == nwords) begin
                  have_desc <= 1'b1;
                  state <= st_upd;
               end
            end
            st_upd: begin
               if (bad_code) begin
                  have_desc <= 1'b0;
                  state <= st_done;
               end else begin
                  left <= step_of(sz);
                  blk_left <= (md == `CODE_BLOCK) ? cnt_b : 16'h0001;
                  state <= st_rd;
               end
            end
            st_rd: if (mem_ack) begin
               data <= mem_rdata;
               left <= left - beat;
               if (left == beat) begin
                  left <= step_of(sz);
                  state <= st_wr;
               end
            end
            st_wr: if (mem_ack) begin
               left <= left - beat;
               if (left == beat) begin
                  left <= step_of(sz);
                  blk_left <= blk_left - 16'h0001;
                  if (md != `CODE_BLOCK || blk_left == 16'h0001) begin
                     widx <= 3'h0;
                     state <= st_wb;
                  end else begin
                     state <= st_rd;
                  end
               end
            end
            st_wb: begin
               if (mem_ack || wb_skip) begin
                  widx <= widx + 3'h1;
                  if (widx + 3'h1 == nwords) begin
                     state <= chain_go ? st_desc : st_done;
                     if (chain_go) begin
                        desc_base <= desc_base + {27'h0, nwords, 2'h0};
                        widx <= 3'h0;
                     end
                  end
               end
            end
            st_done: state <= st_idle;
            default: state <= st_idle;
         endcase
      end
   end
   // descriptor capture and address/count update
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mode_a <= 8'h00;
         mode_b <= 8'h00;
         src <= 32'h0000_0000;
         dst <= 32'h0000_0000;
         cnt_a <= 16'h0000;
         cnt_b <= 16'h0000;
      end else if (state == st_desc && mem_ack) begin
         // internal copy only, no cpu access path
         case (widx)
            3'h0: begin
               mode_a <= mem_rdata[31:24];
               mode_b <= mem_rdata[23:16];
               if (!full_addr_mode) begin
                  src <= mem_rdata & `SHORT_ADDR_MASK;
               end
            end
            3'h1: begin
               if (full_addr_mode) begin
                  src <= mem_rdata;
               end else begin
                  mode_b <= mem_rdata[31:24];
                  dst <= mem_rdata & `SHORT_ADDR_MASK;
               end
            end
            3'h2: begin
               if (full_addr_mode) begin
                  dst <= mem_rdata;
               end else begin
                  cnt_a <= mem_rdata[31:16];
                  cnt_b <= mem_rdata[15:0];
               end
            end
            default: begin
               cnt_a <= mem_rdata[31:16];
               cnt_b <= mem_rdata[15:0];
            end
         endcase
      end else if (state == st_rd && mem_ack && left == beat) begin
         // repeat/block area side holds its address
         if (!(md != `CODE_NORMAL && mode_b[`AREA_SIDE_BIT])) begin
            src <= stepped(src, mode_a[`STEP_FIELD_HI:`STEP_FIELD_LO], sz);
         end
      end else if (state == st_wr && mem_ack && left == beat) begin
         if (!(md != `CODE_NORMAL && !mode_b[`AREA_SIDE_BIT])) begin
            dst <= stepped(dst, mode_b[`STEP_FIELD_HI:`STEP_FIELD_LO], sz);
         end
         if (md == `CODE_BLOCK ? blk_left == 16'h0001 : 1'b1) begin
            // repeat mode reloads the count from its copy
            cnt_a <= (md == `CODE_REPEAT && next_cnt == 16'h0000) ?
               cnt_b : next_cnt;
         end
      end
   end
   // bus port drive, all outputs registered
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         mem_req <= 1'b0;
         pending <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         mem_be <= 4'h0;
      end else begin
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_be <= 4'hf;
         pending <= (pending || mem_req) && !mem_ack; // no reissue on waits
         if (!mem_ack && !mem_req && !pending) begin
            case (state)
               st_vec: begin
                  mem_req <= 1'b1;
                  mem_addr <= vector_base + {22'h0, held_vec, 2'h0};
               end
               st_desc: begin
                  mem_req <= 1'b1;
                  mem_addr <= desc_base + {27'h0, widx, 2'h0};
               end
               st_rd, st_wr: begin
                  mem_req <= 1'b1;
                  mem_we <= (state == st_wr);
                  mem_addr <= cur_addr;
                  mem_wdata <= data;
                  mem_be <= (beat == 3'h1) ? 4'h1 :
                     ((beat == 3'h2) ? 4'h3 : 4'hf);
               end
               st_wb: if (!wb_skip) begin
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= desc_base + {27'h0, widx, 2'h0};
                  mem_wdata <= (widx == 3'h1 && full_addr_mode) ? src :
                     (widx == 3'h2 && full_addr_mode) ? dst :
                     (widx == 3'h0 && full_addr_mode) ?
                     {mode_a, mode_b, 16'h0000} :
                     (widx == 3'h0) ? {mode_a, src[23:0]} :
                     (widx == 3'h1) ? {mode_b, dst[23:0]} :
                     {cnt_a, cnt_b};
               end
               default: mem_req <= 1'b0;
            endcase
         end
      end
   end

   // completion: clear enable on last, cpu irq per select
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         act_done <= 1'b0;
         clear_enable <= 1'b0;
         cpu_irq <= 1'b0;
         busy <= 1'b0;
      end else begin
         busy <= (state != st_idle);
         act_done <= (state == st_done);
         clear_enable <= 1'b0;
         cpu_irq <= 1'b0;
         if (state == st_wb && widx + 3'h1 == nwords && !chain_go &&
             (mem_ack || wb_skip)) begin
            // no completion check when chaining
            clear_enable <= last_xfer;
            cpu_irq <= last_xfer || mode_b[`IRQ_EVERY_BIT];
         end
      end
   end
   a_done_after_wb: assert property (@(posedge clock) disable iff (!rstn)
      (state == st_done) |=> act_done)
      else $error("done pulse missing");
   a_bad_no_bus: assert property (@(posedge clock) disable iff (!rstn)
      (state == st_upd && bad_code) |=> !mem_req[*2])
      else $error("bus access on prohibited code");
   a_vec_first: assert property (@(posedge clock) disable iff (!rstn)
      (state == st_idle && act_req && !read_skip) |=> state == st_vec)
      else $error("vector not read first");
   a_odd_split: assert property (@(posedge clock) disable iff (!rstn)
      (mem_req && state == st_rd && mem_addr[0]) |-> mem_be == 4'h1)
      else $error("odd access not split");
   a_mid_split: assert property (@(posedge clock) disable iff (!rstn)
      (mem_req && state == st_rd && mem_addr[1:0] == 2'h2) |->
      mem_be != 4'hf)
      else $error("4n+2 access not split");
   a_chain_keep: assert property (@(posedge clock) disable iff (!rstn)
      (state == st_wb && chain_go) |=> !clear_enable)
      else $error("enable cleared while chaining");
   a_fixed_skip: assert property (@(posedge clock) disable iff (!rstn)
      (state == st_wb && wb_skip) |=> !(mem_req && mem_we))
      else $error("fixed address written back");
   a_irq_every: assert property (@(posedge clock) disable iff (!rstn)
      $rose(cpu_irq) |-> $past(mode_b[`IRQ_EVERY_BIT]) ||
      $past(last_xfer))
      else $error("cpu irq without cause");
endmodule : interrupt_transfer_ctrl

// ### verif/mem_model.sv
// Purpose: memory partner of the transfer controller bus
// Assumes: one request outstanding, mem_req is a one-cycle pulse
// Notes: slow adds wait cycles; log_q keeps {we, addr} of each request
module mem_model (
   input wire logic clock,
   input wire logic rstn,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [3:0] mem_be,
   input wire logic [1:0] slow,
   output logic [31:0] mem_rdata,
   output logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] store [logic [29:0]];
   logic [32:0] log_q [$];
   logic [31:0] w;
   function automatic logic [31:0] rd(input logic [31:0] a);
      return store.exists(a[31:2]) ? store[a[31:2]] : 32'h0000_0000;
   endfunction : rd
   task automatic poke(input logic [31:0] a, input logic [31:0] d);
      store[a[31:2]] = d;
   endtask : poke
   // answer each request after slow cycles, write lanes by enable
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h5a5a_5a5a;
      forever begin
         @(posedge clock);
         if (mem_req === 1'b1 && rstn === 1'b1) begin
            w = rd(mem_addr);
            for (int b = 0; b < 4; b++)
               if (mem_we && mem_be[b]) w[8*b +: 8] = mem_wdata[8*b +: 8];
            if (mem_we) store[mem_addr[31:2]] = w;
            log_q.push_back({mem_we, mem_addr});
            repeat (slow) @(posedge clock);
            #1 mem_ack = 1'b1;
            mem_rdata = w;
            @(posedge clock);
            #1 mem_ack = 1'b0;
            mem_rdata = ~w; // no stale data once the answer is over
         end
      end
   end
endmodule : mem_model

// ### verif/tb_interrupt_transfer_ctrl.sv
// Purpose: self-checking bench of the interrupt transfer controller
// Assumes: vector table at 0x100 (0x180 in t_full), descriptors and data in mem_model
// Notes: chained descriptors are taken to follow each other in memory
module tb_interrupt_transfer_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rstn, act_req, full_addr_mode, read_skip, mem_ack;
   logic [7:0] act_vector;
   logic [31:0] vector_base, mem_rdata, mem_addr, mem_wdata;
   logic mem_req, mem_we, act_done, clear_enable, cpu_irq, busy;
   logic [3:0] mem_be;
   logic [1:0] slow;
   int bad_count, comparisons, irq_n, clr_n;
   interrupt_transfer_ctrl dut_u (.clock(clock), .rstn(rstn),
      .act_req(act_req), .act_vector(act_vector),
      .vector_base(vector_base), .full_addr_mode(full_addr_mode),
      .read_skip(read_skip), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_be(mem_be), .act_done(act_done),
      .clear_enable(clear_enable), .cpu_irq(cpu_irq), .busy(busy));
   mem_model mem_u (.clock(clock), .rstn(rstn), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
      .mem_be(mem_be), .slow(slow), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // pulses last one cycle, so one count per edge
   always @(posedge clock) begin
      if (cpu_irq === 1'b1) irq_n++;
      if (clear_enable === 1'b1) clr_n++;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   function automatic logic [7:0] ma(input logic [1:0] md, sz, sm);
      return {md, sz, sm, 2'h0};
   endfunction : ma
   function automatic logic [7:0] mb(input logic ce, cc, ie,
                                     input logic [1:0] dm);
      return {ce, cc, ie, 1'b0, dm, 2'h0};
   endfunction : mb
   // requests of one kind whose address matches a above bit sh
   function automatic int n_req(input logic we, input logic [31:0] a,
                                input int sh);
      int n;
      n = 0;
      foreach (mem_u.log_q[i])
         if (mem_u.log_q[i][32] === we && (mem_u.log_q[i][31:0] >> sh)
             === (a >> sh)) n++;
      return n;
   endfunction : n_req
   // memory is live before any descriptor is placed in it
   task automatic put_short(input logic [31:0] da, input logic [7:0] a,
      input logic [7:0] b, input logic [31:0] s, d, c);
      mem_u.poke(da, {a, s[23:0]});
      mem_u.poke(da + 32'h0000_0004, {b, d[23:0]});
      mem_u.poke(da + 32'h0000_0008, c);
   endtask : put_short
   task automatic activate(input logic [7:0] vec);
      irq_n = 0;
      clr_n = 0;
      mem_u.log_q.delete();
      act_vector = vec;
      act_req = 1'b1;
      @(posedge clock);
      #1 act_req = 1'b0;
      for (int k = 0; k < 400 && act_done !== 1'b1; k++) begin
         @(posedge clock);
         #1;
      end
      check({31'h0, act_done}, 32'h0000_0001);
      repeat (2) @(posedge clock);
      #1;
      check({31'h0, busy}, 32'h0000_0000);
   endtask : activate
   task automatic t_normal;
      mem_u.poke(32'h0000_010c, 32'h0000_0200);
      put_short(32'h0000_0200, ma(2'h0, 2'h2, 2'h2), mb(0, 0, 0, 2'h2),
         32'h0000_1000, 32'h0000_1100, 32'h0003_0000);
      for (int i = 0; i < 3; i++)
         mem_u.poke(32'h0000_1000 + 4 * i, 32'hcafe_0000 + i);
      activate(8'h03);
      check(mem_u.log_q[0], {1'b0, 32'h0000_010c});
      check(mem_u.rd(32'h0000_1100), 32'hcafe_0000);
      check(mem_u.rd(32'h0000_0200), 32'h2800_1004);
      check(mem_u.rd(32'h0000_0204), 32'h0800_1104);
      check(mem_u.rd(32'h0000_0208), 32'h0002_0000);
      check(irq_n, 0);
      activate(8'h03);
      check(mem_u.rd(32'h0000_1104), 32'hcafe_0001);
      read_skip = 1'b1;
      mem_u.poke(32'h0000_0200, 32'h2800_1000);
      activate(8'h03);
      check(n_req(1'b0, 32'h0000_0200, 8), 0);
      check(mem_u.rd(32'h0000_1108), 32'hcafe_0002);
      check(irq_n, 1);
      check(clr_n, 1);
      read_skip = 1'b0;
   endtask : t_normal
   task automatic t_full;
      full_addr_mode = 1'b1;
      slow = 2'h2;
      vector_base = 32'h0000_0180;
      mem_u.poke(32'h0000_0190, 32'h0000_0300);
      mem_u.poke(32'h0000_0300, {ma(2'h0, 2'h0, 2'h3),
         mb(0, 0, 1, 2'h0), 16'h0000});
      mem_u.poke(32'h0000_0304, 32'h8000_1203);
      mem_u.poke(32'h0000_0308, 32'h0000_1300);
      mem_u.poke(32'h0000_030c, 32'h0005_0000);
      activate(8'h04);
      check(mem_u.rd(32'h0000_0304), 32'h8000_1202);
      check(n_req(1'b0, 32'h8000_1203, 8), 1);
      check(n_req(1'b1, 32'h0000_0308, 2), 0);
      check(mem_u.rd(32'h0000_030c), 32'h0004_0000);
      check(irq_n, 1);
      full_addr_mode = 1'b0;
      slow = 2'h0;
      vector_base = 32'h0000_0100;
   endtask : t_full
   task automatic t_bad;
      mem_u.poke(32'h0000_0114, 32'h0000_0400);
      for (int i = 0; i < 2; i++) begin
         put_short(32'h0000_0400, i ? ma(2'h0, 2'h3, 2'h2) :
            ma(2'h3, 2'h0, 2'h2), mb(0, 0, 0, 2'h2), 32'h0000_1400,
            32'h0000_1500, 32'h0001_0000);
         activate(8'h05);
         check(n_req(1'b0, 32'h0000_1400, 8), 0);
         check(n_req(1'b1, 32'h0000_1500, 8), 0);
      end
   endtask : t_bad
   task automatic t_chain;
      mem_u.poke(32'h0000_0118, 32'h0000_0500);
      for (int i = 0; i < 2; i++) begin
         put_short(32'h0000_0500, ma(2'h0, 2'h2, 2'h2),
            mb(1, i, 0, 2'h2), 32'h0000_1600, 32'h0000_1700,
            i ? 32'h0005_0000 : 32'h0001_0000);
         put_short(32'h0000_050c, ma(2'h0, 2'h2, 2'h2),
            mb(0, 0, 0, 2'h2), 32'h0000_1800, 32'h0000_1900, 32'h0003_0000);
         mem_u.poke(32'h0000_1600, 32'h1111_0000 + i);
         mem_u.poke(32'h0000_1800, 32'h2222_0000);
         mem_u.poke(32'h0000_1900, 32'h0000_0000);
         activate(8'h06);
         check(mem_u.rd(32'h0000_1700), 32'h1111_0000 + i);
         check(mem_u.rd(32'h0000_1900), i ? 0 : 32'h2222_0000);
         check(clr_n, 0);
      end
   endtask : t_chain
   task automatic t_split;
      mem_u.poke(32'h0000_011c, 32'h0000_0600);
      for (int i = 0; i < 2; i++) begin
         put_short(32'h0000_0600, ma(2'h0, i ? 2'h2 : 2'h1, 2'h0),
            mb(0, 0, 0, 2'h0), i ? 32'h0000_1a02 : 32'h0000_1a01,
            32'h0000_1b00, 32'h0001_0000);
         activate(8'h07);
         check(n_req(1'b0, 32'h0000_1a00, 8) > 1, 1);
         check(n_req(1'b1, 32'h0000_0604, 2), 0);
      end
   endtask : t_split
   task automatic t_area;
      mem_u.poke(32'h0000_0120, 32'h0000_0700);
      mem_u.poke(32'h0000_1c00, 32'h3333_0000);
      mem_u.poke(32'h0000_1c04, 32'h3333_0001);
      put_short(32'h0000_0700, ma(2'h2, 2'h2, 2'h2), mb(0, 0, 0, 2'h2),
         32'h0000_1c00, 32'h0000_1d00, 32'h0001_0002);
      activate(8'h08);
      check(mem_u.rd(32'h0000_1d00), 32'h3333_0001);
      check(mem_u.rd(32'h0000_0700), 32'ha800_1c08);
      check(mem_u.rd(32'h0000_0704), 32'h0800_1d00);
      check(irq_n, 1);
      put_short(32'h0000_0700, ma(2'h1, 2'h2, 2'h2), 8'h18,
         32'h0000_1c04, 32'h0000_1e00, 32'h0001_0001);
      activate(8'h08);
      check(mem_u.rd(32'h0000_1e00), 32'h3333_0001);
      check(mem_u.rd(32'h0000_0700), 32'h6800_1c04);
      check(mem_u.rd(32'h0000_0704), 32'h1800_1e04);
      check(irq_n, 0);
   endtask : t_area
   task automatic stop_test;
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test
   initial begin
      {rstn, act_req, full_addr_mode, read_skip} = 4'h0;
      act_vector = 8'h00;
      vector_base = 32'h0000_0100;
      slow = 2'h0;
      bad_count = 0;
      comparisons = 0;
      repeat (8) @(posedge clock);
      #1 rstn = 1'b1;
      t_normal();
      t_full();
      t_bad();
      t_chain();
      t_split();
      t_area();
      stop_test();
   end
   // whole run needs well under a thousand cycles; this cuts a hang short
   initial begin
      #200000;
      bad_count++;
      stop_test();
   end
endmodule : tb_interrupt_transfer_ctrl
